//--- core/gpm_ctrl.sv
// Notes on behaviour
// (R1) Normal by default; doze on low current.
// (R2) Leave doze on high current or wake.
// (R3) Nonzero wait: deep-doze when timer expires.
// (R4) Zero wait: deep-doze at once if flagged.
// (R5) Bus activity ends deep-doze.
// (R6) Exit keeps flag only if wait positive.
// (R7) Deep-doze may stretch bus up to 4 ms.
// (R8) Leave deep-doze on high current or wake.
// (R9) Storage needs relaxed voltage and low current.
// (R10) Storage entered on low voltage or request.
// (R11) Only own-address activity wakes storage.
// (R12) Shutdown pin only for low-voltage storage.
// (R13) Storage wake clears the storage request.
// (R14) Hold old reported values 3 s after storage.
// (R15) Host sees exit via voltage or flag.
// (R16) Host wakes device before charging.
// (R17) Storage unavailable in single-wire mode.
// (R18) Software reset counts per reset type.
// (R19) Wake comparator fires while dozing.
// (R20) Sense code zero disables comparator.
// (R21) Each nonzero sense code has two thresholds.
// (R22) Flash writes only at or above voltage threshold.
// (R23) Requests wait for qualifying conditions.
`timescale 1ns/10ps
`default_nettype none
module gpm_ctrl (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Measurements.
    input wire logic signed [15:0] avg_current_i,
    input wire logic [15:0] voltage_i,
    input wire logic signed [15:0] sense_i,
    input wire logic ocv_valid_i,
    // Configuration.
    input wire logic doze_en_i,
    input wire logic [15:0] doze_current_i,
    input wire logic [15:0] store_current_i,
    input wire logic [15:0] store_voltage_i,
    input wire logic [15:0] flash_ok_voltage_i,
    input wire logic [15:0] deep_wait_i,
    input wire logic sense_select_high_bit_i,
    input wire logic sense_select_low_bit_i,
    input wire logic wake_range_i,
    input wire logic single_wire_i,
    // Host subcommands, one-cycle pulses.
    input wire logic set_deep_doze_subcommand_i,
    input wire logic set_store_req_i,
    input wire logic sw_reset_i,
    input wire logic [1:0] reset_type_i,
    input wire logic [1:0] reset_data_sel_i,
    input wire logic flash_wr_req_i,
    // Bus activity.
    input wire logic bus_activity_i,
    input wire logic bus_own_addr_i,
    input wire logic bus_xfer_i,
    // Status.
    output logic [1:0] state_o,
    output logic deep_doze_flag_o,
    output logic store_req_o,
    output logic shutdown_en_o,
    output logic hold_report_o,
    output logic stretch_o,
    output logic flash_wr_ok_o,
    output logic flash_wr_refused_o,
    output logic wake_irq_o,
    output logic [7:0] reset_data_o
);

    gpm_pkg::gpm_state_t state_q;
    logic [15:0] wait_q;
    logic deep_flag_q;
    logic store_req_q;
    logic low_v_entry_q;
    logic [gpm_pkg::HOLD_W-1:0] hold_q;
    logic [gpm_pkg::STALL_W-1:0] stall_q;
    logic cmp_en;
    logic wake;
    logic [15:0] cur_mag;
    logic doze_ok;
    logic store_ok;
    logic store_low_v;
    logic leave_deep;
    logic leave_store;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    gpm_wake_cmp u_wake (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .sense_sel_i({sense_select_high_bit_i, sense_select_low_bit_i}),
        .wake_range_i(wake_range_i),
        .dozing_i(state_q == gpm_pkg::PM_DOZE || state_q == gpm_pkg::PM_DEEP),
        .sense_i(sense_i),
        .enabled_o(cmp_en),
        .wake_o(wake)
    );

    gpm_rst_cnt u_rcnt (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .sw_rst_i(sw_reset_i),
        .rst_type_i(reset_type_i),
        .rd_sel_i(reset_data_sel_i),
        .rd_data_o(reset_data_o)
    );

    // ------------------------------------------------------------------
    // Conditions
    // ------------------------------------------------------------------
    assign cur_mag = avg_current_i[15] ? 16'(-avg_current_i)
                                       : 16'(avg_current_i);
    assign doze_ok = doze_en_i && (avg_current_i < $signed(doze_current_i));
    assign store_low_v = voltage_i < store_voltage_i;
    assign store_ok = !single_wire_i && ocv_valid_i // R17
                      && (cur_mag < store_current_i) // R9
                      && (store_low_v || store_req_q); // R10
    assign leave_deep = bus_activity_i // R5
                        || !doze_ok || wake; // R8
    assign leave_store = bus_activity_i && bus_own_addr_i; // R11

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_q <= gpm_pkg::PM_NORMAL;
        else
        begin
            case (state_q)
                gpm_pkg::PM_NORMAL:
                    if (store_ok)
                        state_q <= gpm_pkg::PM_STORE; // R10
                    else if (doze_ok)
                        state_q <= gpm_pkg::PM_DOZE; // R1
                gpm_pkg::PM_DOZE:
                    if (!doze_ok || wake)
                        state_q <= gpm_pkg::PM_NORMAL; // R2
                    else if (deep_wait_i == 16'h0 && deep_flag_q)
                        state_q <= gpm_pkg::PM_DEEP; // R4 R23
                    else if (deep_wait_i != 16'h0 && wait_q == 16'h0)
                        state_q <= gpm_pkg::PM_DEEP; // R3
                gpm_pkg::PM_DEEP:
                    if (leave_deep)
                        state_q <= gpm_pkg::PM_NORMAL; // R5 R8
                gpm_pkg::PM_STORE:
                    if (leave_store || single_wire_i)
                        state_q <= gpm_pkg::PM_NORMAL; // R11 R17
                default:
                    state_q <= gpm_pkg::PM_NORMAL;
            endcase
        end
    end

    // Deep-doze wait timer, loaded on doze entry.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wait_q <= 16'h0000;
        else if (state_q != gpm_pkg::PM_DOZE)
            wait_q <= deep_wait_i;
        else if (wait_q != 16'h0)
            wait_q <= wait_q - 16'h0001; // R3
    end

    // ------------------------------------------------------------------
    // Host flags
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            deep_flag_q <= 1'b0;
        else if (set_deep_doze_subcommand_i)
            deep_flag_q <= 1'b1; // R4 R23
        else if (state_q == gpm_pkg::PM_DEEP && leave_deep
                 && $signed(deep_wait_i) <= 16'sh0)
            deep_flag_q <= 1'b0; // R6
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            store_req_q <= 1'b0;
        else if (set_store_req_i)
            store_req_q <= 1'b1; // R23
        else if (state_q == gpm_pkg::PM_STORE && leave_store)
            store_req_q <= 1'b0; // R13
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            low_v_entry_q <= 1'b0;
        else if (state_q == gpm_pkg::PM_NORMAL && store_ok)
            low_v_entry_q <= store_low_v; // R12
        else if (state_q != gpm_pkg::PM_STORE)
            low_v_entry_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            hold_q <= '0;
        else if (state_q == gpm_pkg::PM_STORE && leave_store)
            hold_q <= gpm_pkg::HOLD_W'(gpm_pkg::HOLD_CYC); // R14
        else if (hold_q != '0)
            hold_q <= hold_q - gpm_pkg::HOLD_W'(1);
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            stall_q <= '0;
        else if (state_q == gpm_pkg::PM_DEEP && bus_xfer_i && stall_q == '0)
            stall_q <= gpm_pkg::STALL_W'(gpm_pkg::STALL_CYC); // R7
        else if (stall_q != '0)
            stall_q <= stall_q - gpm_pkg::STALL_W'(1);
    end

    // Flash update gate.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flash_wr_ok_o <= 1'b0;
            flash_wr_refused_o <= 1'b0;
        end
        else
        begin
            flash_wr_ok_o <= flash_wr_req_i
                             && voltage_i >= flash_ok_voltage_i; // R22
            flash_wr_refused_o <= flash_wr_req_i
                                  && voltage_i < flash_ok_voltage_i; // R22
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign state_o = state_q;
    assign deep_doze_flag_o = deep_flag_q;
    assign store_req_o = store_req_q;
    assign shutdown_en_o = (state_q == gpm_pkg::PM_STORE) && low_v_entry_q;
    assign hold_report_o = hold_q != '0;
    assign stretch_o = stall_q != '0;
    assign wake_irq_o = wake;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    doze_exit_a: assert property ( // R2
        state_q == gpm_pkg::PM_DOZE && wake
        |=> state_q == gpm_pkg::PM_NORMAL)
        else $error("doze not left");
    deep_exit_a: assert property ( // R5
        state_q == gpm_pkg::PM_DEEP && bus_activity_i
        |=> state_q == gpm_pkg::PM_NORMAL)
        else $error("deep-doze not left on activity");
    deep_entry_a: assert property ( // R4
        state_q == gpm_pkg::PM_DOZE && doze_ok && !wake
        && deep_wait_i == 16'h0 && deep_flag_q
        |=> state_q == gpm_pkg::PM_DEEP)
        else $error("no deep entry");
    deep_timed_a: assert property ( // R3
        state_q == gpm_pkg::PM_DOZE && doze_ok && !wake
        && deep_wait_i != 16'h0 && wait_q == 16'h0
        |=> state_q == gpm_pkg::PM_DEEP)
        else $error("no timed deep entry");
    flag_keep_a: assert property ( // R6
        state_q == gpm_pkg::PM_DEEP && bus_activity_i && deep_flag_q
        && $signed(deep_wait_i) > 16'sh0 |=> deep_flag_q)
        else $error("deep-doze flag lost");
    store_gate_a: assert property ( // R9
        $rose(state_q == gpm_pkg::PM_STORE)
        |-> $past(ocv_valid_i) && !$past(single_wire_i))
        else $error("storage entered unqualified");
    store_wake_a: assert property ( // R13
        state_q == gpm_pkg::PM_STORE && leave_store && !set_store_req_i
        |=> !store_req_q ##0 hold_report_o)
        else $error("storage wake incomplete");
    other_addr_a: assert property ( // R11
        state_q == gpm_pkg::PM_STORE && !bus_own_addr_i && !single_wire_i
        |=> state_q == gpm_pkg::PM_STORE)
        else $error("woke on other");
    flash_gate_a: assert property ( // R22
        flash_wr_req_i
        |=> flash_wr_ok_o == ($past(voltage_i) >= $past(flash_ok_voltage_i)))
        else $error("flash gate wrong");
    cmp_off_a: assert property (!cmp_en |=> !wake) // R20
        else $error("comparator not disabled");
    shut_a: assert property ( // R12
        state_q == gpm_pkg::PM_NORMAL ##1 state_q == gpm_pkg::PM_STORE
        |-> shutdown_en_o == $past(store_low_v))
        else $error("shutdown gate wrong");
    stretch_a: assert property ( // R7
        stretch_o |=> stretch_o || !stretch_o && $past(stall_q) == 19'h1)
        else $error("stretch cut short");

    doze_c: cover property (state_q == gpm_pkg::PM_DOZE);
    deep_c: cover property (state_q == gpm_pkg::PM_DEEP);
    store_c: cover property (state_q == gpm_pkg::PM_STORE ##1
        state_q == gpm_pkg::PM_NORMAL);
    stall_c: cover property ($rose(stretch_o));

endmodule
`default_nettype wire

//--- core/gpm_pkg.sv
package gpm_pkg;

    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_NORMAL,
        PM_DOZE,
        PM_DEEP,
        PM_STORE
    } gpm_state_t;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int unsigned MEAS_W = 16;
    localparam int unsigned WAIT_W = 16;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned RST_TYPES = 4;
    localparam int unsigned RTYPE_W = 2;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned STALL_MS = 4;
    localparam int unsigned STALL_CYC = STALL_MS * 1000000 / CLK_NS;
    localparam int unsigned HOLD_S = 3;
    localparam int unsigned HOLD_CYC = HOLD_S * 1000 * 1000000 / CLK_NS;
    localparam int unsigned HOLD_W = 29;
    localparam int unsigned STALL_W = 19;

    // ------------------------------------------------------------------
    // Wake comparator thresholds, in units of 0.1 mV
    // ------------------------------------------------------------------
    localparam logic [1:0] SNS_OFF = 2'h0;
    localparam logic [6:0] WTH_10 = 7'h0a;
    localparam logic [6:0] WTH_22 = 7'h16;
    localparam logic [6:0] WTH_46 = 7'h2e;
    localparam logic [6:0] WTH_98 = 7'h62;

endpackage

//--- core/gpm_wake_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module gpm_wake_cmp (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Configuration.
    input wire logic [1:0] sense_sel_i,
    input wire logic wake_range_i,
    input wire logic dozing_i,
    // Sense voltage, signed, 0.1 mV units.
    input wire logic signed [15:0] sense_i,
    // Result.
    output logic enabled_o,
    output logic wake_o
);

    logic [6:0] thr;
    logic [15:0] mag;

    // ------------------------------------------------------------------
    // Threshold selection
    // ------------------------------------------------------------------
    always_comb
    begin
        case (sense_sel_i)
            2'h1: thr = wake_range_i ? gpm_pkg::WTH_22
                                     : gpm_pkg::WTH_10; // R21
            2'h2: thr = wake_range_i ? gpm_pkg::WTH_46
                                     : gpm_pkg::WTH_22; // R21
            2'h3: thr = wake_range_i ? gpm_pkg::WTH_98
                                     : gpm_pkg::WTH_46; // R21
            default: thr = 7'h7f;
        endcase
    end

    assign enabled_o = (sense_sel_i != gpm_pkg::SNS_OFF); // R20
    assign mag = sense_i[15] ? 16'(-sense_i) : 16'(sense_i);

    // Either direction raises the internal interrupt while dozing.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wake_o <= 1'b0;
        else
            wake_o <= enabled_o && dozing_i && (mag > {9'h0, thr}); // R19
    end

endmodule
`default_nettype wire

//--- core/gpm_rst_cnt.sv
`timescale 1ns/10ps
`default_nettype none
module gpm_rst_cnt (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Software reset event.
    input wire logic sw_rst_i,
    input wire logic [1:0] rst_type_i,
    // Read port.
    input wire logic [1:0] rd_sel_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] cnt_q [gpm_pkg::RST_TYPES];

    // ------------------------------------------------------------------
    // One saturating counter per reset type
    // ------------------------------------------------------------------
    for (genvar g = 0; g < gpm_pkg::RST_TYPES; g++)
    begin : g_cnt
        always_ff @(posedge mclk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
                cnt_q[g] <= 8'h00;
            else if (sw_rst_i && rst_type_i == 2'(g) && cnt_q[g] != 8'hff)
                cnt_q[g] <= cnt_q[g] + 8'h01; // R18
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= cnt_q[rd_sel_i]; // R18
    end

endmodule
`default_nettype wire

//--- dv/gpm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module gpm_host_model (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Bench requests and device stall.
    input wire logic send_i,
    input wire logic own_i,
    input wire logic stretch_i,
    // Bus activity seen by the device.
    output logic activity_o,
    output logic own_addr_o,
    output logic xfer_o
);
    logic pend_q;

    // --------------------
    // Bus activity
    // --------------------
    // The address qualifier drops with the activity, never lingers.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            activity_o <= 1'b0;
            own_addr_o <= 1'b0;
        end
        else
        begin
            activity_o <= send_i;
            own_addr_o <= send_i & own_i;
        end
    end

    // --------------------
    // Transfer start
    // --------------------
    // A transfer waits while the device stretches the lines.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pend_q <= 1'b0;
            xfer_o <= 1'b0;
        end
        else
        begin
            pend_q <= (send_i | pend_q) & stretch_i;
            xfer_o <= (send_i | pend_q) & ~stretch_i;
        end
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk_i, rst_b_i, ocv_valid_i, doze_en_i, wake_range_i, single_wire_i;
    logic sense_select_high_bit_i, sense_select_low_bit_i, sw_reset_i;
    logic set_deep_doze_subcommand_i, set_store_req_i, flash_wr_req_i;
    logic bus_activity_i, bus_own_addr_i, bus_xfer_i, host_send, host_own;
    logic signed [15:0] avg_current_i, sense_i;
    logic [15:0] voltage_i, doze_current_i, store_current_i, store_voltage_i;
    logic [15:0] flash_ok_voltage_i, deep_wait_i;
    logic [1:0] reset_type_i, reset_data_sel_i, state_o;
    logic deep_doze_flag_o, store_req_o, shutdown_en_o, hold_report_o;
    logic stretch_o, flash_wr_ok_o, flash_wr_refused_o, wake_irq_o;
    logic [7:0] reset_data_o;
    logic [6:0] thr_tab [6] = '{gpm_pkg::WTH_10, gpm_pkg::WTH_22,
        gpm_pkg::WTH_22, gpm_pkg::WTH_46, gpm_pkg::WTH_46, gpm_pkg::WTH_98};
    int n_mismatch = 0;
    int n_checks = 0;

    gpm_ctrl dut (.mclk_i, .rst_b_i, .avg_current_i, .voltage_i, .sense_i,
        .ocv_valid_i, .doze_en_i, .doze_current_i, .store_current_i,
        .store_voltage_i, .flash_ok_voltage_i, .deep_wait_i,
        .sense_select_high_bit_i, .sense_select_low_bit_i, .wake_range_i,
        .single_wire_i, .set_deep_doze_subcommand_i, .set_store_req_i,
        .sw_reset_i, .reset_type_i, .reset_data_sel_i, .flash_wr_req_i,
        .bus_activity_i, .bus_own_addr_i, .bus_xfer_i, .state_o,
        .deep_doze_flag_o, .store_req_o, .shutdown_en_o, .hold_report_o,
        .stretch_o, .flash_wr_ok_o, .flash_wr_refused_o, .wake_irq_o,
        .reset_data_o);

    gpm_host_model host (.mclk_i, .rst_b_i, .send_i(host_send),
        .own_i(host_own), .stretch_i(stretch_o), .activity_o(bus_activity_i),
        .own_addr_o(bus_own_addr_i), .xfer_o(bus_xfer_i));

    always #5 mclk_i = ~mclk_i;

    // --------------------
    // Tasks
    // --------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // Waits for the state to reach, or to leave, the given value.
    task automatic wait_st(input logic [1:0] e, input bit leave);
        int k;
        k = 0;
        while (k < 60 && ((state_o === e) == leave))
        begin
            @(posedge mclk_i);
            k++;
        end
        chk(8'((state_o === e) != leave), 8'h1);
    endtask

    // One-cycle pulse on a host request line.
    task automatic pulse(input int k);
        @(posedge mclk_i);
        case (k)
            0: set_deep_doze_subcommand_i <= 1'b1;
            1: set_store_req_i <= 1'b1;
            2: sw_reset_i <= 1'b1;
            3: flash_wr_req_i <= 1'b1;
            default: host_send <= 1'b1;
        endcase
        @(posedge mclk_i);
        {set_deep_doze_subcommand_i, set_store_req_i, sw_reset_i} <= '0;
        {flash_wr_req_i, host_send} <= '0;
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // --------------------
    // Watchdog
    // --------------------
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    // --------------------
    // Tests
    // --------------------
    initial
    begin
        {mclk_i, rst_b_i, ocv_valid_i, doze_en_i, wake_range_i} = '0;
        {single_wire_i, sense_select_high_bit_i, sense_select_low_bit_i} = '0;
        {set_deep_doze_subcommand_i, set_store_req_i, sw_reset_i} = '0;
        {flash_wr_req_i, host_send, host_own, reset_type_i} = '0;
        {reset_data_sel_i, avg_current_i, sense_i} = '0;
        voltage_i = 16'h0e00;
        doze_current_i = 16'h0064;
        store_current_i = 16'h0032;
        store_voltage_i = 16'h0c80;
        flash_ok_voltage_i = 16'h0e00;
        deep_wait_i = 16'h7fff;
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(8'(state_o), 8'h0);
        doze_en_i <= 1'b1;
        wait_st(2'h1, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            {sense_select_high_bit_i, sense_select_low_bit_i} <= 2'(i / 2 + 1);
            wake_range_i <= 1'(i % 2);
            sense_i <= 16'(thr_tab[i]);
            repeat (4) @(posedge mclk_i);
            chk(8'(wake_irq_o), 8'h0);
            sense_i <= (i % 2) ? -16'(thr_tab[i]) - 16'sh1
                               : 16'(thr_tab[i]) + 16'sh1;
            repeat (2) @(posedge mclk_i);
            chk(8'(wake_irq_o), 8'h1);
            wait_st(2'h1, 1'b1);
            sense_i <= '0;
            wait_st(2'h1, 1'b0);
        end
        {sense_select_high_bit_i, sense_select_low_bit_i} <= 2'h0;
        sense_i <= 16'sh0100;
        repeat (4) @(posedge mclk_i);
        chk(8'(wake_irq_o), 8'h0);
        chk(8'(state_o), 8'h1);
        sense_i <= '0;
        doze_en_i <= 1'b0;
        wait_st(2'h0, 1'b0);
        deep_wait_i <= 16'h0014;
        doze_en_i <= 1'b1;
        wait_st(2'h1, 1'b0);
        wait_st(2'h2, 1'b0);
        pulse(0);
        host_own <= 1'b1;
        pulse(4);
        wait_st(2'h2, 1'b1);
        chk(8'(deep_doze_flag_o), 8'h1);
        chk(8'(stretch_o), 8'h1);
        {sense_select_high_bit_i, sense_select_low_bit_i} <= 2'h1;
        wait_st(2'h2, 1'b0);
        sense_i <= 16'sh0040;
        wait_st(2'h2, 1'b1);
        sense_i <= '0;
        wait_st(2'h1, 1'b0);
        avg_current_i <= 16'sh00c8;
        wait_st(2'h1, 1'b1);
        repeat (2) @(posedge mclk_i);
        chk(8'(state_o), 8'h0);
        {doze_en_i, deep_wait_i, avg_current_i} <= '0;
        pulse(0);
        repeat (2) @(posedge mclk_i);
        chk({deep_doze_flag_o, 5'h0, state_o}, 8'h80);
        doze_en_i <= 1'b1;
        wait_st(2'h2, 1'b0);
        pulse(4);
        wait_st(2'h2, 1'b1);
        repeat (2) @(posedge mclk_i);
        chk(8'(deep_doze_flag_o), 8'h0);
        wait_st(2'h1, 1'b0);
        repeat (4) @(posedge mclk_i);
        chk(8'(state_o), 8'h1);
        doze_en_i <= 1'b0;
        wait_st(2'h0, 1'b0);
        pulse(1);
        repeat (2) @(posedge mclk_i);
        chk({store_req_o, 5'h0, state_o}, 8'h80);
        single_wire_i <= 1'b1;
        ocv_valid_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk(8'(state_o), 8'h0);
        single_wire_i <= 1'b0;
        wait_st(2'h3, 1'b0);
        chk(8'(shutdown_en_o), 8'h0);
        host_own <= 1'b0;
        pulse(4);
        repeat (4) @(posedge mclk_i);
        chk(8'(state_o), 8'h3);
        host_own <= 1'b1;
        pulse(4);
        wait_st(2'h0, 1'b0);
        chk(8'({store_req_o, hold_report_o}), 8'h1);
        voltage_i <= 16'h0b00;
        wait_st(2'h3, 1'b0);
        chk(8'(shutdown_en_o), 8'h1);
        voltage_i <= 16'h0e00;
        pulse(4);
        wait_st(2'h0, 1'b0);
        ocv_valid_i <= 1'b0;
        avg_current_i <= 16'sh0100;
        reset_type_i <= 2'h2;
        pulse(2);
        pulse(2);
        reset_type_i <= 2'h1;
        pulse(2);
        reset_data_sel_i <= 2'h2;
        repeat (3) @(posedge mclk_i);
        chk(reset_data_o, 8'h02);
        reset_data_sel_i <= 2'h1;
        repeat (2) @(posedge mclk_i);
        chk(reset_data_o, 8'h01);
        reset_data_sel_i <= 2'h0;
        repeat (2) @(posedge mclk_i);
        chk(reset_data_o, 8'h00);
        pulse(3);
        @(posedge mclk_i);
        chk(8'({flash_wr_ok_o, flash_wr_refused_o}), 8'h2);
        voltage_i <= 16'h0dff;
        pulse(3);
        @(posedge mclk_i);
        chk(8'({flash_wr_ok_o, flash_wr_refused_o}), 8'h1);
        chk(8'(stretch_o), 8'h1);
        chk(8'(state_o), 8'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
